/* File: rtl/branch_cache_regs.vh */
// Register offsets, field positions, reset values and counts for the
// branch cache tuning and lock block.
// Assumes an 8-bit register port with an 8-bit address.
`ifndef BRANCH_CACHE_REGS_VH
`define BRANCH_CACHE_REGS_VH

// Register offsets.
`define ACC_HIGH_ADDR     8'h9A
`define TUNING_ADDR       8'hA2
`define LOCK_CTRL_ADDR    8'hA4
`define IRQ_STATUS_ADDR   8'hA5
`define IRQ_MASK_ADDR     8'hA6

// Reset values.
`define ACC_HIGH_RESET    8'h00
`define TUNING_RESET      8'h04
`define LOCK_CTRL_RESET   8'h3E
`define SLOT_PTR_RESET    6'h3E
`define IRQ_MASK_RESET    3'h0
`define TUN_ALG_RESET     1'b0
`define TUN_FIX_RESET     1'b1
`define TUN_THR_RESET     2'h0
`define TUN_LOW_RESET     4'h0
`define PUSH_EN_RESET     1'b0

// Tuning register fields.
`define TUN_LOW_MSB       7
`define TUN_LOW_LSB       4
`define TUN_ALG_BIT       3
`define TUN_FIX_BIT       2
`define TUN_THR_MSB       1
`define TUN_THR_LSB       0

// Lock control fields.
`define LCK_PUSH_BIT      7
`define LCK_POP_BIT       6
`define LCK_PTR_MSB       5

// Accumulator register fields.
`define ACC_OVF_BIT       7
`define ACC_HIGH_MSB      6

// Interrupt status bits.
`define IRQ_OVF_BIT       0
`define IRQ_PUSH_BIT      1
`define IRQ_UNLOCK_BIT    2

// Accumulator width and last slot of the cache.
`define ACC_WIDTH         12
`define LAST_SLOT         6'h3F

`endif

/* File: rtl/miss_accum.v */
// Twelve-bit cache miss penalty accumulator with a sticky overflow flag.
// Assumes the stall input and the load request come from logic on sys_clk.
`timescale 1ns/100ps
`include "branch_cache_regs.vh"

module miss_accum (
    // Clock and reset.
    input  wire        sys_clk,
    input  wire        resetn,
    // Stall count and load of the upper field.
    input  wire        miss_stall,
    input  wire        load_high,
    input  wire [6:0]  load_value,
    // Accumulator state.
    output wire [11:0] acc_value,
    output wire        acc_overflow,
    output wire        overflow_event
);

    reg  [11:0] acc_q;
    reg         ovf_q;
    wire        wrap;

    // An increment from all ones wraps to zero and counts as an overflow.
    assign wrap = miss_stall && (acc_q == 12'hFFF);

    // A load replaces the count, so no overflow of the old count survives.
    always @(posedge sys_clk) begin
        if (!resetn) begin
            acc_q <= 12'h000;
            ovf_q <= 1'b0;
        end else if (load_high) begin
            acc_q <= {load_value, 5'h00};
            ovf_q <= 1'b0;
        end else begin
            if (miss_stall) begin
                acc_q <= acc_q + 12'h001;
            end
            if (wrap) begin
                ovf_q <= 1'b1;
            end
        end
    end

    assign acc_value      = acc_q;
    assign acc_overflow   = ovf_q;
    assign overflow_event = wrap && !load_high;

endmodule // miss_accum

/* File: rtl/replace_sel.v */
// Victim slot chooser: rebound sweep or pseudo-random pick.
// Assumes limit is the highest slot that may be replaced.
`timescale 1ns/100ps
`include "branch_cache_regs.vh"

module replace_sel (
    // Clock and reset.
    input  wire       sys_clk,
    input  wire       resetn,
    // Control.
    input  wire       advance,
    input  wire       random_mode,
    input  wire [5:0] limit,
    // Chosen slot.
    output wire [5:0] victim
);

    reg  [5:0] sweep_q;
    reg        down_q;
    reg  [5:0] lfsr_q;
    wire [5:0] sweep_slot;
    wire [5:0] rand_slot;

    // Keep both choices inside the replaceable range.
    assign sweep_slot = (sweep_q > limit) ? limit : sweep_q;
    assign rand_slot  = (lfsr_q > limit) ? (lfsr_q & limit) : lfsr_q;
    assign victim     = random_mode ? rand_slot : sweep_slot;

    // The sweep turns at either end; the LFSR runs free.
    always @(posedge sys_clk) begin
        if (!resetn) begin
            sweep_q <= 6'h00;
            down_q  <= 1'b0;
            lfsr_q  <= 6'h01;
        end else begin
            lfsr_q <= {lfsr_q[4:0], lfsr_q[5] ^ lfsr_q[4]};
            if (advance && !random_mode) begin
                if (!down_q && sweep_slot >= limit) begin
                    down_q  <= 1'b1;
                    sweep_q <= sweep_slot - 6'h01;
                end else if (down_q && sweep_slot == 6'h00) begin
                    down_q  <= 1'b0;
                    sweep_q <= 6'h01;
                end else if (down_q) begin
                    sweep_q <= sweep_slot - 6'h01;
                end else begin
                    sweep_q <= sweep_slot + 6'h01;
                end
            end
        end
    end

endmodule // replace_sel

/* File: rtl/branch_cache_tuning_lock.v */
// Tuning, slot locking and miss penalty counting for a branch target cache.
// Assumes the core register port and the fill path run on sys_clk.
`timescale 1ns/100ps
`include "branch_cache_regs.vh"

module branch_cache_tuning_lock (
    // Clock and reset.
    input  wire        sys_clk,
    input  wire        resetn,
    // Register port.
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // Fetch side: stall and completed fills.
    input  wire        miss_stall,
    input  wire        fill_valid,
    input  wire [7:0]  fill_cycles,
    input  wire        fill_table_read,
    input  wire [15:0] fill_addr,
    // Cache array write request.
    output reg         cache_wr,
    output reg  [5:0]  cache_wr_slot,
    output reg  [15:0] cache_wr_addr,
    output reg         cache_wr_lock,
    // Lock boundary for the cache array.
    output reg  [5:0]  lock_boundary,
    output reg         lock_active,
    // Interrupt.
    output reg         irq
);

    // Register port address match, shared by the write and read decode.
    function addr_hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // Slot is protected when the pointer is non-zero and it lies above.
    // A zero pointer frees the whole cache, so no slot is protected
    // then; a runaway push therefore cannot freeze every slot.
    function slot_locked;
        input [5:0] slot;
        input [5:0] ptr;
        begin
            slot_locked = (ptr != 6'h00) && (slot > ptr);
        end
    endfunction

    // Highest slot that the replacement logic may use.
    // With a zero pointer nothing is locked and every slot may be used.
    function [5:0] replace_limit;
        input [5:0] ptr;
        begin
            if (ptr == 6'h00) begin
                replace_limit = `LAST_SLOT;
            end else begin
                replace_limit = ptr;
            end
        end
    endfunction

    // Register state.
    reg        alg_q;
    reg        fix_q;
    reg  [1:0] thr_q;
    reg  [3:0] low_field_q;
    reg        push_en_q;
    reg  [5:0] ptr_q;
    reg  [5:0] ptr_d;
    reg  [2:0] irq_status_q;
    reg  [2:0] irq_status_d;
    reg  [2:0] irq_mask_q;
    reg  [7:0] rdata_d;

    // Decoded accesses.
    wire       wr_acc;
    wire       wr_tun;
    wire       wr_lck;
    wire       wr_ist;
    wire       wr_imk;
    wire       rd_acc;
    wire       pop_req;

    // Fill decision.
    reg        do_write;
    reg        do_push;
    reg        do_replace;
    reg  [5:0] slot_d;

    // Submodule results.
    wire [11:0] acc_value;
    wire        acc_overflow;
    wire        overflow_event;
    wire [5:0]  victim;
    wire [5:0]  limit;

    // Interrupt events of this cycle and the mask for the next one.
    wire        evt_overflow;
    wire        evt_push;
    wire        evt_unlock;
    wire [2:0]  mask_next;

    // Register images as software reads them.
    wire [7:0]  acc_view;
    wire [7:0]  tun_view;
    wire [7:0]  lck_view;

    // Address decode of the register port. The port never waits, so
    // each strobe is decoded and acts in its own cycle only.
    assign wr_acc  = reg_wr && addr_hit(reg_addr, `ACC_HIGH_ADDR);
    assign wr_tun  = reg_wr && addr_hit(reg_addr, `TUNING_ADDR);
    assign wr_lck  = reg_wr && addr_hit(reg_addr, `LOCK_CTRL_ADDR);
    assign wr_ist  = reg_wr && addr_hit(reg_addr, `IRQ_STATUS_ADDR);
    assign wr_imk  = reg_wr && addr_hit(reg_addr, `IRQ_MASK_ADDR);
    assign rd_acc  = reg_rd && addr_hit(reg_addr, `ACC_HIGH_ADDR);
    assign pop_req = wr_lck && reg_wdata[`LCK_POP_BIT];
    assign limit   = replace_limit(ptr_q);

    // Events that set sticky status bits. The unlock event marks the
    // pointer stepping onto zero, after which no slot stays locked.
    assign evt_overflow = overflow_event;
    assign evt_push     = do_push;
    assign evt_unlock   = (ptr_d == 6'h00) && (ptr_q != 6'h00);
    assign mask_next    = wr_imk ? reg_wdata[2:0] : irq_mask_q;

    // The overflow flag tops the upper field; the pop bit reads zero.
    assign acc_view = {acc_overflow, acc_value[11:5]};
    assign tun_view = {low_field_q, alg_q, fix_q, thr_q};
    assign lck_view = {push_en_q, 1'b0, ptr_q};

    // Miss penalty accumulator. A write of the upper field reloads it,
    // with the five low bits restarting from zero.
    miss_accum u_miss_accum (
        .sys_clk        (sys_clk),
        .resetn         (resetn),
        .miss_stall     (miss_stall),
        .load_high      (wr_acc),
        .load_value     (reg_wdata[`ACC_HIGH_MSB:0]),
        .acc_value      (acc_value),
        .acc_overflow   (acc_overflow),
        .overflow_event (overflow_event)
    );

    // Replacement victim chooser, stepped on each replacing fill.
    // Pushed and fixed-slot writes do not step it, so they leave the
    // rebound sweep where it was.
    replace_sel u_replace_sel (
        .sys_clk     (sys_clk),
        .resetn      (resetn),
        .advance     (do_replace),
        .random_mode (alg_q),
        .limit       (limit),
        .victim      (victim)
    );

    // Decide whether and where a completed fill is written.
    // Push comes first, then the fixed slot, then the threshold; a table
    // read that neither pushes nor is fixed is treated like any miss.
    always @* begin
        do_write   = 1'b0;
        do_push    = 1'b0;
        do_replace = 1'b0;
        slot_d     = victim;
        if (fill_valid) begin
            if (fill_table_read && push_en_q) begin
                do_write = 1'b1;
                do_push  = 1'b1;
                slot_d   = ptr_q;
            end else if (fill_table_read && fix_q) begin
                do_write = 1'b1;
                slot_d   = 6'h00;
            end else if (fill_cycles > {6'h00, thr_q}) begin
                do_write   = 1'b1;
                do_replace = 1'b1;
                slot_d     = victim;
            end
        end
    end

    // Push and pop may coincide; each moves the pointer by one.
    // Together they cancel on the pointer, while the push still writes
    // its slot, which then stays unlocked.
    always @* begin
        ptr_d = ptr_q;
        if (do_push && !pop_req) begin
            ptr_d = ptr_q - 6'h01;
        end else if (pop_req && !do_push) begin
            ptr_d = ptr_q + 6'h01;
        end
    end

    // Tuning and lock control registers.
    // The low field only changes on an upper field read, so software
    // sees a matched pair of fields when it reads them in order.
    always @(posedge sys_clk) begin
        if (!resetn) begin
            alg_q       <= `TUN_ALG_RESET;
            fix_q       <= `TUN_FIX_RESET;
            thr_q       <= `TUN_THR_RESET;
            low_field_q <= `TUN_LOW_RESET;
            push_en_q   <= `PUSH_EN_RESET;
            ptr_q       <= `SLOT_PTR_RESET;
        end else begin
            if (wr_tun) begin
                alg_q <= reg_wdata[`TUN_ALG_BIT];
                fix_q <= reg_wdata[`TUN_FIX_BIT];
                thr_q <= reg_wdata[`TUN_THR_MSB:`TUN_THR_LSB];
            end
            if (rd_acc) begin
                low_field_q <= acc_value[4:1];
            end
            if (wr_lck) begin
                push_en_q <= reg_wdata[`LCK_PUSH_BIT];
            end
            ptr_q <= ptr_d;
        end
    end

    // Sticky interrupt bits; a new event wins over a clear, so an event
    // in the cycle of a write-one-to-clear is never lost.
    always @* begin
        irq_status_d = irq_status_q;
        if (wr_ist) begin
            irq_status_d = irq_status_q & ~reg_wdata[2:0];
        end
        if (evt_overflow) begin
            irq_status_d[`IRQ_OVF_BIT] = 1'b1;
        end
        if (evt_push) begin
            irq_status_d[`IRQ_PUSH_BIT] = 1'b1;
        end
        if (evt_unlock) begin
            irq_status_d[`IRQ_UNLOCK_BIT] = 1'b1;
        end
    end

    // Interrupt status, mask and output. The output is taken from the
    // next status and mask, so it follows them without a lag cycle.
    always @(posedge sys_clk) begin
        if (!resetn) begin
            irq_status_q <= 3'h0;
            irq_mask_q   <= `IRQ_MASK_RESET;
            irq          <= 1'b0;
        end else begin
            irq_status_q <= irq_status_d;
            if (wr_imk) begin
                irq_mask_q <= reg_wdata[2:0];
            end
            irq <= |(irq_status_d & mask_next);
        end
    end

    // Read data multiplexer; unmapped addresses read zero.
    // Reading has no side effect here; the capture sits in the registers.
    always @* begin
        rdata_d = 8'h00;
        case (reg_addr)
            `ACC_HIGH_ADDR: begin
                rdata_d = acc_view;
            end
            `TUNING_ADDR: begin
                rdata_d = tun_view;
            end
            `LOCK_CTRL_ADDR: begin
                rdata_d = lck_view;
            end
            `IRQ_STATUS_ADDR: begin
                rdata_d = {5'h00, irq_status_q};
            end
            `IRQ_MASK_ADDR: begin
                rdata_d = {5'h00, irq_mask_q};
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    // Read data stands only in the cycle after the read strobe.
    // Zero at all other times keeps a stale value from being taken.
    always @(posedge sys_clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Cache array write request, registered so the array sees a clean
    // one-cycle pulse. A pushed write always lands on the pointer slot;
    // any other write must miss the locked slots.
    always @(posedge sys_clk) begin
        if (!resetn) begin
            cache_wr      <= 1'b0;
            cache_wr_slot <= 6'h00;
            cache_wr_addr <= 16'h0000;
            cache_wr_lock <= 1'b0;
        end else begin
            cache_wr      <= do_write && (do_push ||
                             !slot_locked(slot_d, ptr_q));
            cache_wr_slot <= slot_d;
            cache_wr_addr <= {fill_addr[15:2], 2'h0};
            cache_wr_lock <= do_push;
        end
    end

    // Lock boundary for the array, taken from the next pointer so that
    // it moves on the same edge as the internal pointer.
    always @(posedge sys_clk) begin
        if (!resetn) begin
            lock_boundary <= `SLOT_PTR_RESET;
            lock_active   <= 1'b1;
        end else begin
            lock_boundary <= ptr_d;
            lock_active   <= (ptr_d != 6'h00);
        end
    end

endmodule // branch_cache_tuning_lock

/* File: rtl/README_NONE.v */
// Holds no logic of its own.
// Assumes nothing of its surroundings.

/* File: tb/branch_cache_properties.sv */
// Port checks for the branch cache tuning and lock block.
// Assumes it is bound into that block and sees the shared header.
`timescale 1ns/100ps
`include "branch_cache_regs.vh"
module branch_cache_properties (
    // Clock and reset.
    input wire logic        sys_clk,
    input wire logic        resetn,
    // Register port.
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // Fetch side.
    input wire logic        miss_stall,
    input wire logic        fill_valid,
    input wire logic [7:0]  fill_cycles,
    input wire logic        fill_table_read,
    input wire logic [15:0] fill_addr,
    // Cache array side.
    input wire logic        cache_wr,
    input wire logic [5:0]  cache_wr_slot,
    input wire logic [15:0] cache_wr_addr,
    input wire logic        cache_wr_lock,
    input wire logic [5:0]  lock_boundary,
    input wire logic        lock_active,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    // A pop written while no fill lands in the same cycle.
    sequence s_pop;
        reg_wr && reg_addr == `LOCK_CTRL_ADDR && reg_wdata[6] && !fill_valid;
    endsequence
    // A lock write that no register write can cancel.
    sequence s_push;
        cache_wr && cache_wr_lock && !$past(reg_wr);
    endsequence
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data seen outside a read answer");
    a_pop_reads_zero: assert property (
        $past(reg_rd) && $past(reg_addr) == `LOCK_CTRL_ADDR |-> !reg_rdata[6])
        else $error("pop bit read back as one");
    a_pop_step: assert property (
        s_pop |=> lock_boundary == $past(lock_boundary) + 6'd1)
        else $error("pop did not step the pointer up by one");
    a_push_slot: assert property (s_push |->
        cache_wr_slot == $past(lock_boundary)
        && lock_boundary == $past(lock_boundary) - 6'd1)
        else $error("push used the wrong slot or pointer step");
    a_fill_source: assert property (
        cache_wr |-> $past(fill_valid)
        && cache_wr_addr == ($past(fill_addr) & 16'hFFFC))
        else $error("cache write without its fill or segment");
    a_lock_flag: assert property (
        lock_active == (lock_boundary != 6'h00))
        else $error("lock flag disagrees with the pointer");
    a_slot_limit: assert property (
        cache_wr && !cache_wr_lock && lock_active
        |-> cache_wr_slot <= lock_boundary)
        else $error("replacement hit a locked slot");
    a_ptr_steady: assert property (
        $past(resetn) && !$past(reg_wr) && !$past(fill_valid)
        |-> $stable(lock_boundary))
        else $error("pointer moved with no push or pop");
endmodule // branch_cache_properties
bind branch_cache_tuning_lock branch_cache_properties u_props (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .miss_stall(miss_stall),
    .fill_valid(fill_valid), .fill_cycles(fill_cycles),
    .fill_table_read(fill_table_read), .fill_addr(fill_addr),
    .cache_wr(cache_wr), .cache_wr_slot(cache_wr_slot),
    .cache_wr_addr(cache_wr_addr), .cache_wr_lock(cache_wr_lock),
    .lock_boundary(lock_boundary), .lock_active(lock_active), .irq(irq)
);

/* File: tb/fetch_model.sv */
// Behavioural fetch path: stalls the core, then hands over one fill.
// Assumes the testbench calls its fill task by hierarchical name.
`timescale 1ns/100ps
module fetch_model (
    // Clock.
    input  wire logic  sys_clk,
    // Stall and fill outputs.
    output logic        miss_stall,
    output logic        fill_valid,
    output logic [7:0]  fill_cycles,
    output logic        fill_table_read,
    output logic [15:0] fill_addr
);
    // Idle outputs at time zero.
    initial begin
        miss_stall = 1'b0;
        fill_valid = 1'b0;
        fill_cycles = 8'h00;
        fill_table_read = 1'b0;
        fill_addr = 16'h0000;
    end
    // Stall n cycles, pulse the fill, then scramble the stale qualifiers.
    task automatic fill(input logic [7:0] n, input logic t,
                        input logic [15:0] a);
        repeat (n) @(posedge sys_clk) miss_stall <= 1'b1;
        @(posedge sys_clk);
        miss_stall <= 1'b0;
        fill_valid <= 1'b1;
        fill_cycles <= n;
        fill_table_read <= t;
        fill_addr <= a;
        @(posedge sys_clk);
        fill_valid <= 1'b0;
        fill_cycles <= ~n;
        fill_table_read <= ~t;
        fill_addr <= ~a;
        repeat (2) @(posedge sys_clk);
    endtask
endmodule // fetch_model

/* File: tb/tb_top.sv */
// Register level testbench for the branch cache tuning and lock block.
// Assumes the fetch model and bound checker are compiled before it.
`timescale 1ns/100ps
`include "branch_cache_regs.vh"
module tb_top;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    wire  [7:0]  reg_rdata, fill_cycles;
    wire         miss_stall, fill_valid, fill_table_read;
    wire  [15:0] fill_addr, cache_wr_addr;
    wire         cache_wr, cache_wr_lock, lock_active, irq;
    wire  [5:0]  cache_wr_slot, lock_boundary;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          wr_n = 0;
    logic [15:0] wr_addr = 16'h0000;
    logic [5:0]  wr_slot = 6'h00;
    logic        wr_lock = 1'b0;
    logic [7:0]  rd_last = 8'h00;
    logic [7:0]  acc_hi = 8'h00;
    // Clock at 25 MHz.
    always #20 sys_clk = ~sys_clk;
    branch_cache_tuning_lock u_branch_cache_tuning_lock (
        .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .miss_stall(miss_stall),
        .fill_valid(fill_valid), .fill_cycles(fill_cycles),
        .fill_table_read(fill_table_read), .fill_addr(fill_addr),
        .cache_wr(cache_wr), .cache_wr_slot(cache_wr_slot),
        .cache_wr_addr(cache_wr_addr), .cache_wr_lock(cache_wr_lock),
        .lock_boundary(lock_boundary), .lock_active(lock_active),
        .irq(irq));
    fetch_model u_fetch_model (
        .sys_clk(sys_clk), .miss_stall(miss_stall),
        .fill_valid(fill_valid), .fill_cycles(fill_cycles),
        .fill_table_read(fill_table_read), .fill_addr(fill_addr));
    // Log each cache write at mid-cycle, where it has settled.
    always @(negedge sys_clk) begin
        if (cache_wr === 1'b1) begin
            wr_n++;
            wr_addr = cache_wr_addr;
            wr_slot = cache_wr_slot;
            wr_lock = cache_wr_lock;
        end
    end
    task automatic give_verdict;
        if (bad_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk("read data", {8'h00, reg_rdata}, {8'h00, exp});
        rd_last = reg_rdata;
    endtask
    task automatic see_irq(input logic exp);
        repeat (2) @(posedge sys_clk);
        #1 chk("irq", {15'h0000, irq}, {15'h0000, exp});
    endtask
    // Cut a hung run short.
    initial begin
        #200000;
        bad_count++;
        give_verdict;
    end
    // Main sequence.
    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(`ACC_HIGH_ADDR, 8'h00);
        rd(`TUNING_ADDR, 8'h04);
        rd(`LOCK_CTRL_ADDR, 8'h3E);
        rd(`IRQ_STATUS_ADDR, 8'h00);
        rd(`IRQ_MASK_ADDR, 8'h00);
        rd(8'h10, 8'h00);
        // 37 stall cycles give an upper field of 1 and bits 4..1 of 2.
        u_fetch_model.fill(8'd37, 1'b0, 16'h0101);
        rd(`ACC_HIGH_ADDR, 8'h01);
        acc_hi = rd_last;
        rd(`TUNING_ADDR, 8'h24);
        chk("penalty", {4'h0, acc_hi[6:0], rd_last[7:4], 1'b0},
            16'd36);
        chk("fill count", wr_n[15:0], 16'd1);
        chk("fill addr", wr_addr, 16'h0100);
        wr(`ACC_HIGH_ADDR, 8'h03);
        rd(`ACC_HIGH_ADDR, 8'h03);
        rd(`TUNING_ADDR, 8'h04);
        // 0xFE0 plus 40 wraps to 0x008 and raises overflow.
        wr(`ACC_HIGH_ADDR, 8'h7F);
        u_fetch_model.fill(8'd40, 1'b0, 16'h0202);
        rd(`ACC_HIGH_ADDR, 8'h80);
        rd(`TUNING_ADDR, 8'h44);
        rd(`IRQ_STATUS_ADDR, 8'h01);
        wr(`IRQ_MASK_ADDR, 8'h01);
        see_irq(1'b1);
        wr(`IRQ_STATUS_ADDR, 8'h01);
        see_irq(1'b0);
        wr(`ACC_HIGH_ADDR, 8'h00);
        rd(`ACC_HIGH_ADDR, 8'h00);
        // Threshold 3: a 3-cycle fill is dropped, a 4-cycle one kept.
        wr(`TUNING_ADDR, 8'h03);
        u_fetch_model.fill(8'd3, 1'b0, 16'h0300);
        chk("fill count", wr_n[15:0], 16'd2);
        u_fetch_model.fill(8'd4, 1'b0, 16'h0304);
        chk("fill count", wr_n[15:0], 16'd3);
        chk("slot", {10'h000, wr_slot}, 16'h0002);
        // Random replacement, then a table read forced to slot 0.
        wr(`TUNING_ADDR, 8'h08);
        u_fetch_model.fill(8'd2, 1'b0, 16'h0400);
        chk("fill count", wr_n[15:0], 16'd4);
        wr(`TUNING_ADDR, 8'h04);
        u_fetch_model.fill(8'd1, 1'b1, 16'h2003);
        chk("slot", {10'h000, wr_slot}, 16'h0000);
        chk("lock", {15'h0000, wr_lock}, 16'h0000);
        // Two pushes, a pop, an unlocked table read, a last pop.
        wr(`LOCK_CTRL_ADDR, 8'h80);
        u_fetch_model.fill(8'd1, 1'b1, 16'h1237);
        chk("slot", {10'h000, wr_slot}, 16'h003E);
        chk("addr", wr_addr, 16'h1234);
        chk("lock", {15'h0000, wr_lock}, 16'h0001);
        rd(`LOCK_CTRL_ADDR, 8'hBD);
        rd(`IRQ_STATUS_ADDR, 8'h02);
        u_fetch_model.fill(8'd1, 1'b1, 16'h0041);
        chk("slot", {10'h000, wr_slot}, 16'h003D);
        wr(`LOCK_CTRL_ADDR, 8'h40);
        rd(`LOCK_CTRL_ADDR, 8'h3D);
        u_fetch_model.fill(8'd1, 1'b1, 16'h0500);
        chk("lock", {15'h0000, wr_lock}, 16'h0000);
        rd(`LOCK_CTRL_ADDR, 8'h3D);
        wr(`LOCK_CTRL_ADDR, 8'h40);
        wr(`LOCK_CTRL_ADDR, 8'h3F);
        rd(`LOCK_CTRL_ADDR, 8'h3E);
        give_verdict;
    end
endmodule // tb_top
